// *** verilog/apdm_defs.svh ***
`ifndef APDM_DEFS_SVH
`define APDM_DEFS_SVH

// Register byte addresses
`define APDM_OFF_CTRL_A      32'h0000_0000
`define APDM_OFF_GATE_B      32'h0000_0004
`define APDM_OFF_STATUS      32'h0000_0008

// Control register A fields
`define APDM_A_SLEEP_EN      1
`define APDM_A_FAST_OFF      3
`define APDM_A_ARR_CLK_OFF   4
`define APDM_A_CELL_CLK_OFF  5
`define APDM_A_USED_MASK     8'h3a

// Gate register B fields
`define APDM_B_CTRL0_OFF     2
`define APDM_B_CTRL1_OFF     3
`define APDM_B_CTRL2_OFF     4
`define APDM_B_STROBE_OFF    5
`define APDM_B_LANE_OFF      6
`define APDM_B_USED_MASK     8'h7c

// Reset values
`define APDM_REG_RESET       8'h00

// Idle count and array timing
`define APDM_IDLE_CLOCKS     4'hf
`define APDM_CLK_MHZ         10
`define APDM_STANDBY_NS      70
`define APDM_SLOW_EXTRA_NS   10
`define APDM_SLOW_RATE_MHZ   15
// Least time, rounded up, at least one cycle
`define APDM_STANDBY_CYC     ((`APDM_STANDBY_NS * `APDM_CLK_MHZ + 999) / 1000)
`define APDM_SLOW_EXTRA_CYC  ((`APDM_SLOW_EXTRA_NS * `APDM_CLK_MHZ + 999) / 1000)

`endif

// *** verilog/apdm_pkg.sv ***
package apdm_pkg;
    // Sleep unit states
    typedef enum logic [1:0] {
        APDM_AWAKE,
        APDM_COUNTING,
        APDM_ASLEEP
    } apdm_state_t;

    // Bus slave data phase
    typedef enum logic [1:0] {
        APDM_BUS_IDLE,
        APDM_BUS_WRITE,
        APDM_BUS_READ
    } apdm_bus_t;
endpackage

// *** verilog/apdm_auto_power_down_manager.sv ***
// Contract
// RQ1: Enabled and strobe at idle level, count 15 input clocks, then raise power-down.
// RQ2: Control A bit 1 enables sleep; no counting when off or strobe pulsing.
// RQ3: System feeds input clock below 15 times strobe rate, running while host sleeps.
// RQ4: Control A bit 3 set turns fast mode off; clear means full speed.
// RQ5: Fast off: array standby after 70ns static, delay grows 10ns when slow.
// RQ6: Control A bits 4 and 5 disconnect input clock from array and cells.
// RQ7: Array clock connected and fast on: each input clock change wakes array.
// RQ8: Control B bits 2..6 gate three bus controls, strobe, lane enable.
// RQ9: Software writes zero to unused bits of both control registers.
// RQ10: Both registers clear on power-up only; later resets keep them.
// RQ11: Select low enables memories; high disables flash and static memory.
// RQ12: Select high leaves logic array and port signals running.
// RQ13: Gating and fast controls act independently of power-down mode.
// RQ14: Software should gate unused clock and controls before power-down.
// RQ15: Leave power-down on strobe pulsing, select low or reset.
// RQ16: In power-down block host bus and deselect memories.
// RQ17: Array clock gating never stops clock reaching idle counter.
// RQ18: Counter clears on every strobe change; power-down holds until exit.
// RQ19: Strobe idle polarity is a static configuration input.
`timescale 1ns/1ns
`default_nettype none
`include "apdm_defs.svh"

module apdm_auto_power_down_manager (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        power_up_n_in,
    input  wire logic        strobe_polarity_in,
    input  wire logic        strobe_input_pin_in,
    input  wire logic        clock_input_pin_in,
    input  wire logic        select_input_pin_n_in,
    input  wire logic        bus_ctrl_in_0_in,
    input  wire logic        bus_ctrl_in_1_in,
    input  wire logic        bus_ctrl_in_2_in,
    input  wire logic        byte_lane_enable_in_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             power_down_flag_out,
    output logic             mem_enable_out,
    output logic             host_bus_block_out,
    output logic             array_fast_mode_out,
    output logic             array_standby_out,
    output logic             array_slow_delay_out,
    output logic             array_clock_gate_out,
    output logic             cell_clock_gate_out,
    output logic             array_ctrl_0_out,
    output logic             array_ctrl_1_out,
    output logic             array_ctrl_2_out,
    output logic             array_strobe_out,
    output logic             array_lane_out,
    output logic             logic_array_run_out
);

    localparam logic [3:0] IDLE_CLOCKS = `APDM_IDLE_CLOCKS;
    localparam int         STBY_CYC    = `APDM_STANDBY_CYC;
    localparam int         SLOW_MHZ    = `APDM_SLOW_RATE_MHZ;
    // Window over which input changes are counted to judge the composite rate
    localparam int         RATE_WIN    = `APDM_CLK_MHZ;

    // Elaboration check: both counts must fit their four-bit counters
    if (STBY_CYC < 1 || STBY_CYC > 15 || RATE_WIN < 1 || RATE_WIN > 16) begin : g_count_check
        $error("timing count does not fit its counter");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0]           strb_sync;
        logic [2:0]           clk_sync;
        logic [2:0]           sel_sync;
        logic [2:0]           c0_sync;
        logic [2:0]           c1_sync;
        logic [2:0]           c2_sync;
        logic [2:0]           lane_sync;
        logic                 strb;
        logic                 clk;
        logic                 sel_n;
        logic                 c0;
        logic                 c1;
        logic                 c2;
        logic                 lane;
        logic [7:0]           ctrl_a;
        logic [7:0]           gate_b;
        apdm_pkg::apdm_state_t st;
        logic [3:0]           idle_cnt;
        logic [3:0]           static_cnt;
        logic [3:0]           win_cnt;
        logic [4:0]           chg_cnt;
        logic                 slow;
        logic                 standby;
        apdm_pkg::apdm_bus_t  bus;
        logic [3:0]           addr_word;
        logic [31:0]          rdata;
    } apdm_regs_t;

    apdm_regs_t r;
    apdm_regs_t next_r;

    logic       strb_chg;
    logic       clk_chg;
    logic       in_chg;
    logic       idle_level;
    logic       addr_ok;
    logic [7:0] wbyte;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_r = r;
        // Three-stage sync, accept change when last two agree
        next_r.strb_sync = {r.strb_sync[1:0], strobe_input_pin_in};
        next_r.clk_sync  = {r.clk_sync[1:0], clock_input_pin_in};
        next_r.sel_sync  = {r.sel_sync[1:0], select_input_pin_n_in};
        next_r.c0_sync   = {r.c0_sync[1:0], bus_ctrl_in_0_in};
        next_r.c1_sync   = {r.c1_sync[1:0], bus_ctrl_in_1_in};
        next_r.c2_sync   = {r.c2_sync[1:0], bus_ctrl_in_2_in};
        next_r.lane_sync = {r.lane_sync[1:0], byte_lane_enable_in_in};
        if (r.strb_sync[1] == r.strb_sync[2]) next_r.strb = r.strb_sync[2];
        if (r.clk_sync[1] == r.clk_sync[2]) next_r.clk = r.clk_sync[2];
        if (r.sel_sync[1] == r.sel_sync[2]) next_r.sel_n = r.sel_sync[2];
        if (r.c0_sync[1] == r.c0_sync[2]) next_r.c0 = r.c0_sync[2];
        if (r.c1_sync[1] == r.c1_sync[2]) next_r.c1 = r.c1_sync[2];
        if (r.c2_sync[1] == r.c2_sync[2]) next_r.c2 = r.c2_sync[2];
        if (r.lane_sync[1] == r.lane_sync[2]) next_r.lane = r.lane_sync[2];

        strb_chg   = (r.strb_sync[1] == r.strb_sync[2]) && (r.strb_sync[2] != r.strb);
        // Rising input clock edge; counter sees it whatever the gate bits say
        clk_chg    = (r.clk_sync[1] == r.clk_sync[2]) && r.clk_sync[2] && !r.clk; // RQ17
        idle_level = (r.strb == strobe_polarity_in);                              // RQ19

        // Sleep unit
        unique case (r.st)
            apdm_pkg::APDM_AWAKE: begin
                next_r.idle_cnt = 4'h0;
                if (r.ctrl_a[`APDM_A_SLEEP_EN] && idle_level && !strb_chg) begin // RQ2
                    next_r.st = apdm_pkg::APDM_COUNTING;
                end
            end
            apdm_pkg::APDM_COUNTING: begin
                if (!r.ctrl_a[`APDM_A_SLEEP_EN] || strb_chg || !idle_level) begin
                    next_r.st       = apdm_pkg::APDM_AWAKE;                       // RQ18
                    next_r.idle_cnt = 4'h0;
                end else if (clk_chg) begin
                    next_r.idle_cnt = r.idle_cnt + 4'h1;                          // RQ1
                    if (r.idle_cnt == IDLE_CLOCKS - 4'h1) begin
                        next_r.st = apdm_pkg::APDM_ASLEEP;                        // RQ1
                    end
                end
            end
            apdm_pkg::APDM_ASLEEP: begin
                // Held until strobe activity or select low; reset handled below
                if (strb_chg || !r.sel_n) begin                                   // RQ15
                    next_r.st       = apdm_pkg::APDM_AWAKE;
                    next_r.idle_cnt = 4'h0;
                end
            end
        endcase

        // Array standby when fast mode is off and inputs stay static
        in_chg = (clk_chg && !r.ctrl_a[`APDM_A_ARR_CLK_OFF])
               || (next_r.c0 != r.c0 && !r.gate_b[`APDM_B_CTRL0_OFF])
               || (next_r.c1 != r.c1 && !r.gate_b[`APDM_B_CTRL1_OFF])
               || (next_r.c2 != r.c2 && !r.gate_b[`APDM_B_CTRL2_OFF])
               || (strb_chg && !r.gate_b[`APDM_B_STROBE_OFF])
               || (next_r.lane != r.lane && !r.gate_b[`APDM_B_LANE_OFF]);
        if (!r.ctrl_a[`APDM_A_FAST_OFF]) begin
            // Fast mode never idles the array
            next_r.static_cnt = 4'h0;
            next_r.standby    = 1'b0;                                             // RQ7
        end else if (in_chg) begin
            next_r.static_cnt = 4'h0;
            next_r.standby    = 1'b0;                                             // RQ5
        end else if (r.static_cnt < 4'(STBY_CYC)) begin
            next_r.static_cnt = r.static_cnt + 4'h1;
        end else begin
            next_r.standby = 1'b1;                                                // RQ5
        end

        // Composite rate over a 1 us window; below threshold slows the array
        if (r.win_cnt == 4'(RATE_WIN - 1)) begin
            next_r.win_cnt = 4'h0;
            next_r.chg_cnt = 5'h0;
            next_r.slow    = r.ctrl_a[`APDM_A_FAST_OFF] && (r.chg_cnt < 5'(SLOW_MHZ)); // RQ5
        end else begin
            next_r.win_cnt = r.win_cnt + 4'h1;
            if (in_chg && r.chg_cnt != 5'h1f) next_r.chg_cnt = r.chg_cnt + 5'h1;
        end

        // AHB-Lite slave, zero wait states, always OKAY
        addr_ok = (haddr_in == `APDM_OFF_CTRL_A) || (haddr_in == `APDM_OFF_GATE_B)
                  || (haddr_in == `APDM_OFF_STATUS);
        next_r.bus = apdm_pkg::APDM_BUS_IDLE;
        if (hsel_in && hready_in && htrans_in[1] && addr_ok) begin
            next_r.bus       = hwrite_in ? apdm_pkg::APDM_BUS_WRITE : apdm_pkg::APDM_BUS_READ;
            next_r.addr_word = haddr_in[5:2];
        end
        wbyte = hwdata_in[7:0];
        if (r.bus == apdm_pkg::APDM_BUS_WRITE) begin
            // Unused bits stored as written would be ignored; keep them zero
            if (r.addr_word == 4'h0) next_r.ctrl_a = wbyte & `APDM_A_USED_MASK; // RQ9
            if (r.addr_word == 4'h1) next_r.gate_b = wbyte & `APDM_B_USED_MASK; // RQ9
        end
        next_r.rdata = 32'h0000_0000;
        unique case (haddr_in[5:2])
            4'h0:    next_r.rdata = {24'h00_0000, r.ctrl_a};
            4'h1:    next_r.rdata = {24'h00_0000, r.gate_b};
            4'h2:    next_r.rdata = {29'h0000_0000, r.slow, r.standby,
                                     r.st == apdm_pkg::APDM_ASLEEP};
            default: next_r.rdata = 32'h0000_0000;
        endcase
        // Only decoded words answer; upper address bits would otherwise alias
        if (!addr_ok) next_r.rdata = 32'h0000_0000;

        // Warm reset wakes the unit but keeps the control registers
        if (!rst_n_in) begin
            next_r.st       = apdm_pkg::APDM_AWAKE;                               // RQ15
            next_r.idle_cnt = 4'h0;
            next_r.bus      = apdm_pkg::APDM_BUS_IDLE;
            // Timing state restarts too, else the rate window never leaves X
            next_r.static_cnt = 4'h0;
            next_r.standby    = 1'b0;
            next_r.win_cnt    = 4'h0;
            next_r.chg_cnt    = 5'h0;
            next_r.slow       = 1'b0;
        end
        // Power-up only clears the registers
        if (!power_up_n_in) begin
            next_r.ctrl_a   = `APDM_REG_RESET;                                    // RQ10
            next_r.gate_b   = `APDM_REG_RESET;                                    // RQ10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; warm reset deliberately spares the control registers
    always_ff @(posedge ref_clk_in) begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs; gating follows register bits only, not sleep
    always_ff @(posedge ref_clk_in) begin
        hrdata_out           <= next_r.rdata;
        hreadyout_out        <= 1'b1;
        hresp_out            <= 1'b0;
        power_down_flag_out  <= (next_r.st == apdm_pkg::APDM_ASLEEP);             // RQ18
        mem_enable_out       <= !next_r.sel_n && (next_r.st != apdm_pkg::APDM_ASLEEP); // RQ11 RQ16
        host_bus_block_out   <= (next_r.st == apdm_pkg::APDM_ASLEEP);             // RQ16
        // Fast flag taken a cycle late so it lines up with the standby output
        array_fast_mode_out  <= !r.ctrl_a[`APDM_A_FAST_OFF];                      // RQ4
        array_standby_out    <= next_r.standby;                                   // RQ5
        array_slow_delay_out <= next_r.slow;                                      // RQ5
        array_clock_gate_out <= next_r.clk && !next_r.ctrl_a[`APDM_A_ARR_CLK_OFF];   // RQ6 RQ13
        cell_clock_gate_out  <= next_r.clk && !next_r.ctrl_a[`APDM_A_CELL_CLK_OFF];  // RQ6 RQ13
        array_ctrl_0_out     <= next_r.c0 && !next_r.gate_b[`APDM_B_CTRL0_OFF];   // RQ8
        array_ctrl_1_out     <= next_r.c1 && !next_r.gate_b[`APDM_B_CTRL1_OFF];   // RQ8
        array_ctrl_2_out     <= next_r.c2 && !next_r.gate_b[`APDM_B_CTRL2_OFF];   // RQ8
        array_strobe_out     <= next_r.strb && !next_r.gate_b[`APDM_B_STROBE_OFF]; // RQ8
        array_lane_out       <= next_r.lane && !next_r.gate_b[`APDM_B_LANE_OFF];  // RQ8
        logic_array_run_out  <= 1'b1;                                             // RQ12
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_idle_clock;
        r.st == apdm_pkg::APDM_COUNTING && clk_chg && r.idle_cnt == 4'he
        && r.ctrl_a[`APDM_A_SLEEP_EN] && !strb_chg && idle_level;
    endsequence

    a_sleep_entry: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ1
        s_idle_clock |=> power_down_flag_out)
        else $error("power-down not raised after idle count");

    a_sleep_disabled: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ2
        !r.ctrl_a[`APDM_A_SLEEP_EN] |=> r.st != apdm_pkg::APDM_COUNTING)
        else $error("counting while sleep disabled");

    a_fast_mode: assert property (@(posedge ref_clk_in) disable iff (!power_up_n_in) // RQ4
        array_fast_mode_out == !$past(r.ctrl_a[`APDM_A_FAST_OFF], 1) || $changed(r.ctrl_a))
        else $error("fast mode output wrong");

    a_fast_awake: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ7
        array_fast_mode_out |-> !array_standby_out)
        else $error("standby during fast mode");

    a_warm_keeps: assert property (@(posedge ref_clk_in) disable iff (!power_up_n_in) // RQ10
        (!rst_n_in && r.bus != apdm_pkg::APDM_BUS_WRITE) |=> $stable(r.ctrl_a))
        else $error("warm reset changed control register");

    a_sleep_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ18
        (r.st == apdm_pkg::APDM_ASLEEP && !strb_chg && r.sel_n)
        |=> r.st == apdm_pkg::APDM_ASLEEP)
        else $error("power-down dropped without exit");

    a_select_wake: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ15
        (r.st == apdm_pkg::APDM_ASLEEP && !r.sel_n) |=> !power_down_flag_out)
        else $error("select low did not wake");

    a_sleep_blocks: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ16
        power_down_flag_out |-> host_bus_block_out && !mem_enable_out)
        else $error("bus not blocked in power-down");

    a_strobe_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ8
        r.gate_b[`APDM_B_STROBE_OFF] |-> !array_strobe_out)
        else $error("gated strobe reached array");

    a_cell_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ6
        r.ctrl_a[`APDM_A_CELL_CLK_OFF] |-> !cell_clock_gate_out)
        else $error("gated clock reached cells");

    a_select_mem: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ11
        r.sel_n |-> !mem_enable_out)
        else $error("memory enabled while deselected");

    a_warm_wake: assert property (@(posedge ref_clk_in) disable iff (!power_up_n_in) // RQ15
        !rst_n_in |=> !power_down_flag_out)
        else $error("warm reset did not wake");

    // One counted input clock step; array clock gating must not hide it
    sequence s_count_step;
        r.st == apdm_pkg::APDM_COUNTING && clk_chg && r.idle_cnt != 4'he
        && r.ctrl_a[`APDM_A_SLEEP_EN] && !strb_chg && idle_level;
    endsequence

    a_count_step: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ17
        s_count_step |=> r.idle_cnt == $past(r.idle_cnt) + 4'h1)
        else $error("idle counter missed an input clock");

endmodule // apdm_auto_power_down_manager
`default_nettype wire

// *** testbench/apdm_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host side: address strobe and a crystal input clock that keeps running
module apdm_host_model (
    input  wire logic ref_clk_in,
    input  wire logic pulse_en_in,
    input  wire logic idle_lvl_in,
    input  wire logic clk_run_in,
    output logic      strobe_out,
    output logic      in_clk_out
);
    logic [1:0] div;
    // Strobe period 8 cycles, input clock period 4: well under 15 times the strobe rate
    always @(posedge ref_clk_in) begin
        div <= div + 2'h1;
        strobe_out <= pulse_en_in ? (strobe_out ^ (div == 2'h3)) : idle_lvl_in;
        in_clk_out <= clk_run_in ? (in_clk_out ^ div[0]) : 1'b1;
    end
    // Known start so the synchronisers never see an unknown
    initial begin
        div = 2'h0;
        strobe_out = 1'b1;
        in_clk_out = 1'b1;
    end
endmodule // apdm_host_model
`default_nettype wire

// *** testbench/apdm_auto_power_down_manager_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "apdm_defs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
////////////////////////////////////////////////////////////////////////////////
module apdm_auto_power_down_manager_bench;
    logic        clk = 1'b0;
    logic        rst_n, pu_n, pol, sel_n, c0, c1, c2, lane, pulse, run, hwrite, hready;
    logic        strobe, in_clk, flag, mem_en, blk, fast, stby, slow, agate, cgate, run_o;
    logic        a0, a1, a2, astb, alane, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  a, b;
    int          error_cnt, checked, seed, n, i;
    localparam int CLK_DIV = 4;

    // Half period 50 ns
    always #50 clk = ~clk;

    apdm_auto_power_down_manager dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .power_up_n_in(pu_n), .strobe_polarity_in(pol),
        .strobe_input_pin_in(strobe), .clock_input_pin_in(in_clk), .select_input_pin_n_in(sel_n),
        .bus_ctrl_in_0_in(c0), .bus_ctrl_in_1_in(c1), .bus_ctrl_in_2_in(c2),
        .byte_lane_enable_in_in(lane), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .power_down_flag_out(flag), .mem_enable_out(mem_en), .host_bus_block_out(blk),
        .array_fast_mode_out(fast), .array_standby_out(stby), .array_slow_delay_out(slow),
        .array_clock_gate_out(agate), .cell_clock_gate_out(cgate), .array_ctrl_0_out(a0),
        .array_ctrl_1_out(a1), .array_ctrl_2_out(a2), .array_strobe_out(astb),
        .array_lane_out(alane), .logic_array_run_out(run_o));

    apdm_host_model host (.ref_clk_in(clk), .pulse_en_in(pulse), .idle_lvl_in(pol),
        .clk_run_in(run), .strobe_out(strobe), .in_clk_out(in_clk));

    ////////////////////////////////////////////////////////////////////////////
    // Expected array input: pin passes only while its blocking bit is clear
    function automatic logic gated(input logic pin, input logic [7:0] r, input int k);
        return pin & ~r[k];
    endfunction

    // Single word transfer; holds each phase until hready is seen high
    task automatic bus(input logic wr, input logic [31:0] ad, input logic [7:0] wd);
        haddr  <= ad;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK("response", 1'b0, hresp)
    endtask

    task automatic rchk(input logic [31:0] ad, input logic [31:0] ex, input string nm);
        bus(1'b0, ad, 8'h00);
        `CHK(nm, ex, rd)
    endtask

    // Bounded wait, since exit and entry latencies pass through synchronisers
    task automatic wait_flag(input logic v, input int lim);
        n = 0;
        while (flag !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        `CHK("power-down flag", v, flag)
    endtask

    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the fewer than a thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        seed = 32'h9347d6ae;
        {rst_n, pu_n, pol, sel_n, c0, c1, c2, lane} = 8'h20;
        {pulse, run, hwrite, htrans, haddr, hwdata} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        pu_n  <= 1'b1;
        @(posedge clk);
        rchk(`APDM_OFF_CTRL_A, 32'h0, "ctrl a reset");
        rchk(`APDM_OFF_GATE_B, 32'h0, "gate b reset");
        bus(1'b1, 32'h0000_0010, 8'hff);
        rchk(32'h0000_0010, 32'h0, "unmapped");
        // Static pins, clock held: every gate and mode bit seen at the array
        for (i = 0; i < 10; i++) begin
            a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            {c0, c1, c2, lane, sel_n} <= (i == 0) ? 5'h1f : 5'($random(seed));
            bus(1'b1, `APDM_OFF_CTRL_A, a & `APDM_A_USED_MASK);
            bus(1'b1, `APDM_OFF_GATE_B, b & `APDM_B_USED_MASK);
            repeat (6) @(posedge clk);
            rchk(`APDM_OFF_CTRL_A, {24'h0, a & `APDM_A_USED_MASK}, "ctrl a");
            rchk(`APDM_OFF_GATE_B, {24'h0, b & `APDM_B_USED_MASK}, "gate b");
            `CHK("fast mode", ~a[`APDM_A_FAST_OFF], fast)
            `CHK("standby", a[`APDM_A_FAST_OFF], stby)
            `CHK("slow delay", a[`APDM_A_FAST_OFF], slow)
            `CHK("array clock", gated(1'b1, a, `APDM_A_ARR_CLK_OFF), agate)
            `CHK("cell clock", gated(1'b1, a, `APDM_A_CELL_CLK_OFF), cgate)
            `CHK("ctrl 0", gated(c0, b, `APDM_B_CTRL0_OFF), a0)
            `CHK("ctrl 1", gated(c1, b, `APDM_B_CTRL1_OFF), a1)
            `CHK("ctrl 2", gated(c2, b, `APDM_B_CTRL2_OFF), a2)
            `CHK("strobe", gated(pol, b, `APDM_B_STROBE_OFF), astb)
            `CHK("lane", gated(lane, b, `APDM_B_LANE_OFF), alane)
            `CHK("mem enable", ~sel_n, mem_en)
            `CHK("array run", 1'b1, run_o)
        end
        // Clock running with fast mode on keeps the array awake
        bus(1'b1, `APDM_OFF_CTRL_A, 8'h00);
        run <= 1'b1;
        // Standby output trails the register write by one cycle
        @(posedge clk);
        for (i = 0; i < 12; i++) begin
            @(posedge clk);
            `CHK("awake", 1'b0, stby)
        end
        // Idle strobe with array clock gated still reaches the counter
        sel_n <= 1'b1;
        bus(1'b1, `APDM_OFF_GATE_B, 8'h7c);
        bus(1'b1, `APDM_OFF_CTRL_A, 8'h32);
        wait_flag(1'b1, 150);
        `CHK("idle span", 1'b1, n >= (`APDM_IDLE_CLOCKS - 1) * CLK_DIV && n <= 80)
        `CHK("bus block", 1'b1, blk)
        `CHK("mem in sleep", 1'b0, mem_en)
        rchk(`APDM_OFF_STATUS, 32'h1, "status");
        bus(1'b1, `APDM_OFF_CTRL_A, 8'h3a);
        repeat (3) @(posedge clk);
        `CHK("fast in sleep", 1'b0, fast)
        `CHK("standby in sleep", 1'b1, stby)
        `CHK("flag holds", 1'b1, flag)
        // Three ways out of power-down
        pulse <= 1'b1;
        wait_flag(1'b0, 20);
        pulse <= 1'b0;
        wait_flag(1'b1, 150);
        sel_n <= 1'b0;
        wait_flag(1'b0, 20);
        repeat (6) @(posedge clk);
        `CHK("mem after exit", 1'b1, mem_en)
        sel_n <= 1'b1;
        wait_flag(1'b1, 150);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wait_flag(1'b0, 20);
        rchk(`APDM_OFF_CTRL_A, 32'h3a, "warm reset keeps");
        // Sleep disabled, then enabled with the strobe pulsing
        bus(1'b1, `APDM_OFF_CTRL_A, 8'h38);
        repeat (150) @(posedge clk);
        `CHK("disabled", 1'b0, flag)
        bus(1'b1, `APDM_OFF_CTRL_A, 8'h3a);
        pulse <= 1'b1;
        repeat (150) @(posedge clk);
        `CHK("pulsing", 1'b0, flag)
        // Low idle level, strap changed only inside reset
        rst_n <= 1'b0;
        pol   <= 1'b0;
        pulse <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_flag(1'b1, 150);
        // Power-up reset clears both registers
        pu_n <= 1'b0;
        repeat (2) @(posedge clk);
        pu_n <= 1'b1;
        @(posedge clk);
        rchk(`APDM_OFF_CTRL_A, 32'h0, "power-up a");
        rchk(`APDM_OFF_GATE_B, 32'h0, "power-up b");
        report_and_stop();
    end
endmodule // apdm_auto_power_down_manager_bench
`default_nettype wire
